// ### core/sdram_pin_pkg.sv
// Constants and command encodings for the SDRAM pin interface
// Contract
// - Data mask high until initialization done
// - Data mask low forever after initialization
// - Dedicated bit-10 pin replaces address bit during SDRAM
// - Strobes and write enable encode each command
// - Clock enable output follows requested enable; memory clock runs regardless of it
// - Command pins float in reset, driven from the first edge after
// - Disable input stops all pin switching except general address bit 10
package sdram_pin_pkg;
  // Command encodings as {row_strobe_n, col_strobe_n, write_en_n}
  localparam logic [2:0] CMD_ACTIVATE  = 3'h3;
  localparam logic [2:0] CMD_READ      = 3'h5;
  localparam logic [2:0] CMD_WRITE     = 3'h4;
  localparam logic [2:0] CMD_PRECHARGE = 3'h2;
  localparam logic [2:0] CMD_REFRESH   = 3'h1;
  localparam logic [2:0] CMD_LOAD_MODE = 3'h0;
  localparam logic [2:0] CMD_NOP       = 3'h7;

  typedef enum logic [2:0] {
    OP_NOP,
    OP_ACTIVATE,
    OP_READ,
    OP_WRITE,
    OP_PRECHARGE,
    OP_REFRESH,
    OP_LOAD_MODE
  } sdram_op_e;

  localparam logic [1:0] CLK_DIV_DEFAULT = 2'h1;

  function automatic logic [2:0] encode_op(input sdram_op_e op);
    unique case (op)
      OP_ACTIVATE:  encode_op = CMD_ACTIVATE;
      OP_READ:      encode_op = CMD_READ;
      OP_WRITE:     encode_op = CMD_WRITE;
      OP_PRECHARGE: encode_op = CMD_PRECHARGE;
      OP_REFRESH:   encode_op = CMD_REFRESH;
      OP_LOAD_MODE: encode_op = CMD_LOAD_MODE;
      default:      encode_op = CMD_NOP;
    endcase
  endfunction
endpackage

// ### core/sdram_cmd_if.sv
// Command path between pin driver and clock generator
`timescale 1ns/10ps
`default_nettype none
interface sdram_cmd_if;
  logic out_en;
  logic clk_level;
  modport drv (output out_en, input  clk_level);
  modport gen (input  out_en, output clk_level);
endinterface
`default_nettype wire

// ### core/sdram_clk_gen.sv
// SDRAM clock divider driving the clock output level
`timescale 1ns/10ps
`default_nettype none
module sdram_clk_gen
  import sdram_pin_pkg::*;
#(
  parameter logic [1:0] DIV = CLK_DIV_DEFAULT
) (
  input wire logic   ref_clk,    // System clock
  input wire logic   nrst,       // Async reset, active low
  sdram_cmd_if.gen   cmd         // Enable in, clock level out
);
  logic [1:0] cnt_r;
  logic       lvl_r;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= 2'h0;
      lvl_r <= 1'b0;
    end else if (!cmd.out_en) begin
      cnt_r <= 2'h0;
      lvl_r <= 1'b0;
    end else if (cnt_r == DIV - 2'h1) begin
      cnt_r <= 2'h0;
      lvl_r <= ~lvl_r;
    end else begin
      cnt_r <= cnt_r + 2'h1;
    end
  end

  assign cmd.clk_level = lvl_r;
endmodule
`default_nettype wire

// ### core/sdram_pin_interface.sv
// SDRAM pin driver: command strobes, mask, bit 10, clock enable, clock
`timescale 1ns/10ps
`default_nettype none
module sdram_pin_interface
  import sdram_pin_pkg::*;
(
  input  wire logic      ref_clk,              // System clock, 100 MHz
  input  wire logic      nrst,                 // Async reset, active low
  input  wire logic      sdram_iface_disable,  // High stops pin switching
  input  wire logic      init_done,            // Initialization sequence finished
  input  wire sdram_op_e op,                   // Operation for this cycle
  input  wire logic      sdram_access,         // SDRAM access in progress
  input  wire logic      sdram_a10_val,        // Bit-10 value for SDRAM access
  input  wire logic      ext_addr_bit10,       // General address bit 10
  input  wire logic      clk_en_req,           // Requested memory clock enable
  output logic           sdram_row_strobe_n,   // Row strobe level
  output logic           sdram_col_strobe_n,   // Column strobe level
  output logic           sdram_write_en_n,     // Write enable level
  output logic           sdram_clk_en,         // Memory clock enable
  output logic           sdram_addr_bit10,     // Dedicated bit-10 level
  output logic           sdram_data_mask,      // Data mask level
  output logic           sdram_clk_out,        // SDRAM clock level
  output logic           addr_bit10_out,       // General address bit 10 level
  output logic           addr_bit10_oe,        // General bit 10 drive enable
  output logic           ctrl_oe,              // Command/mask pins drive enable
  output logic           clk_oe                // Clock pin drive enable
);
  logic       oe_r;
  logic       init_seen_r;
  logic [2:0] cmd_r;
  logic       cke_r;
  logic       a10_r;
  logic       mask_r;
  logic       ab10_r;
  logic       ab10_oe_r;

  sdram_cmd_if cmd_if();

  sdram_clk_gen #(
    .DIV (CLK_DIV_DEFAULT)
  ) u_clk (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .cmd     (cmd_if.gen)
  );

  // Pins float in reset, driven from first edge after release
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      oe_r <= 1'b0;
    end else begin
      oe_r <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      init_seen_r <= 1'b0;
    end else if (init_done) begin
      init_seen_r <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mask_r <= 1'b1;
    end else if (!sdram_iface_disable) begin
      mask_r <= ~(init_seen_r | init_done);
    end
  end

  // Command strobes, held at NOP while disabled
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cmd_r <= CMD_NOP;
    end else if (sdram_iface_disable) begin
      cmd_r <= CMD_NOP;
    end else begin
      cmd_r <= encode_op(op);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cke_r <= 1'b1;
    end else if (!sdram_iface_disable) begin
      cke_r <= clk_en_req;
    end
  end

  // An SDRAM access owns bit 10 only while the interface is live
  function automatic logic a10_owned(input logic access, input logic off);
    a10_owned = access & ~off;
  endfunction

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      a10_r <= 1'b1;
    end else if (a10_owned(sdram_access, sdram_iface_disable)) begin
      a10_r <= sdram_a10_val;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ab10_r <= 1'b0;
    end else begin
      ab10_r <= ext_addr_bit10;
    end
  end

  // General bit 10 lets go of its pin while the SDRAM side owns it
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ab10_oe_r <= 1'b0;
    end else begin
      ab10_oe_r <= ~a10_owned(sdram_access, sdram_iface_disable);
    end
  end

  assign cmd_if.out_en = oe_r & ~sdram_iface_disable;

  assign sdram_row_strobe_n = cmd_r[2];
  assign sdram_col_strobe_n = cmd_r[1];
  assign sdram_write_en_n   = cmd_r[0];
  assign sdram_clk_en       = cke_r;
  assign sdram_addr_bit10   = a10_r;
  assign sdram_data_mask    = mask_r;
  assign sdram_clk_out      = cmd_if.clk_level;
  assign addr_bit10_out     = ab10_r;
  assign addr_bit10_oe      = ab10_oe_r;
  assign ctrl_oe            = oe_r;
  assign clk_oe             = oe_r;
endmodule
`default_nettype wire

// ### test/sdram_mem_model.sv
// Behavioural SDRAM device behind pulled-up command pins
`timescale 1ns/10ps
`default_nettype none
module sdram_mem_model (
  input wire logic ref_clk,            // Sampling clock
  input wire logic ctrl_oe,            // Controller drives the pins
  input wire logic sdram_row_strobe_n, // Row strobe
  input wire logic sdram_col_strobe_n, // Column strobe
  input wire logic sdram_write_en_n,   // Write enable
  input wire logic sdram_data_mask,    // Data mask
  output var int   wr_cnt,             // Writes taken
  output var int   rd_cnt              // Reads answered
);
  // Floating pins settle at the pull-up level
  wire logic [3:0] pin = ctrl_oe ? {sdram_row_strobe_n, sdram_col_strobe_n,
                                    sdram_write_en_n, sdram_data_mask} : 4'hf;
  int wr_n = 0;
  int rd_n = 0;
  always @(posedge ref_clk) begin
    if (pin == 4'h8) wr_n <= wr_n + 1;
    if (pin == 4'ha) rd_n <= rd_n + 1;
  end
  assign wr_cnt = wr_n;
  assign rd_cnt = rd_n;
endmodule
`default_nettype wire

// ### test/sdram_pin_asserts.sv
// Checker on the SDRAM pin interface ports
`timescale 1ns/10ps
`default_nettype none
module sdram_pin_asserts
  import sdram_pin_pkg::*;
(
  input wire logic      ref_clk,             // System clock
  input wire logic      nrst,                // Async reset, active low
  input wire logic      sdram_iface_disable, // Interface off
  input wire logic      init_done,           // Initialization finished
  input wire logic      sdram_access,        // SDRAM access owns bit 10
  input wire logic      sdram_a10_val,       // Requested bit-10 level
  input wire logic      clk_en_req,          // Requested clock enable
  input wire logic      sdram_clk_en,        // Clock enable pin
  input wire logic      sdram_addr_bit10,    // Dedicated bit-10 pin
  input wire logic      sdram_data_mask,     // Data mask pin
  input wire logic      sdram_clk_out,       // Memory clock pin
  input wire logic      addr_bit10_oe,       // General bit 10 drive enable
  input wire logic      ctrl_oe,             // Command pins drive enable
  input wire logic      clk_oe,              // Clock pin drive enable
  input wire logic      sdram_row_strobe_n,  // Row strobe pin
  input wire logic      sdram_col_strobe_n,  // Column strobe pin
  input wire logic      sdram_write_en_n,    // Write enable pin
  input wire sdram_op_e op                   // Requested operation
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  wire logic [2:0] cmd = {sdram_row_strobe_n, sdram_col_strobe_n, sdram_write_en_n};
  wire logic       dis = sdram_iface_disable;
  AST_MASK_HOLD: assert property (sdram_data_mask && !init_done |=> sdram_data_mask)
    else $error("mask fell early");
  AST_MASK_LOW: assert property (init_done && !dis |=> !sdram_data_mask)
    else $error("mask not low");
  AST_CMD: assert property (!dis && op == OP_READ |=> cmd == CMD_READ)
    else $error("bad read code");
  AST_DIS: assert property (dis |=> cmd == CMD_NOP && !sdram_clk_out)
    else $error("pins switch while off");
  AST_A10: assert property (sdram_access && !dis |=>
    sdram_addr_bit10 == $past(sdram_a10_val) && !addr_bit10_oe) else $error("bad bit 10");
  AST_CKE: assert property (!dis |=> sdram_clk_en == $past(clk_en_req))
    else $error("bad clock enable");
  AST_OE: assert property ($past(nrst) |-> ctrl_oe && clk_oe)
    else $error("pins not driven");
  AST_CLK: assert property (ctrl_oe && !dis |=> sdram_clk_out != $past(sdram_clk_out))
    else $error("clock stuck");
  cover property (op == OP_WRITE && !sdram_data_mask);
  cover property (init_done && !dis);
  cover property (dis && sdram_access);
endmodule
bind sdram_pin_interface sdram_pin_asserts i_sdram_pin_asserts (.*);
`default_nettype wire

// ### test/sdram_pin_interface_test.sv
// Random bench for the SDRAM pin interface
`timescale 1ns/10ps
`default_nettype none
module sdram_pin_interface_test;
  import sdram_pin_pkg::*;
  logic ref_clk = 0, nrst = 1, sdram_iface_disable = 0, init_done = 0, sdram_access = 0;
  logic sdram_a10_val = 0, ext_addr_bit10 = 0, clk_en_req = 0, em = 1, ek = 1, ea = 1, ec = 0;
  logic live = 0;
  logic sdram_row_strobe_n, sdram_col_strobe_n, sdram_write_en_n, sdram_clk_en, clk_oe;
  logic sdram_addr_bit10, sdram_data_mask, sdram_clk_out, addr_bit10_out, addr_bit10_oe, ctrl_oe;
  sdram_op_e op = OP_NOP;
  int error_cnt = 0, samples_checked = 0, wr = 0, rd = 0, cyc = 0, wr_cnt, rd_cnt;
  sdram_pin_interface i_sdram_pin_interface (.*);
  sdram_mem_model i_sdram_mem_model (.*);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [2:0] enc(input sdram_op_e o);
    case (o)
      OP_ACTIVATE: return 3'h3;
      OP_READ: return 3'h5;
      OP_WRITE: return 3'h4;
      OP_PRECHARGE: return 3'h2;
      OP_REFRESH: return 3'h1;
      OP_LOAD_MODE: return 3'h0;
      default: return 3'h7;
    endcase
  endfunction
  task automatic final_report;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic run(input int n, input logic ph);
    sdram_op_e po;
    logic pd, pa, pe;
    repeat (n) begin
      @(posedge ref_clk);
      po = op; pd = sdram_iface_disable; pa = sdram_access; pe = ext_addr_bit10;
      if (!pd && init_done) em = 0;
      if (pa && !pd) ea = sdram_a10_val;
      if (!pd) ek = clk_en_req;
      ec = live && !pd && !ec;
      live = 1;
      wr += !pd && !em && po == OP_WRITE;
      rd += !pd && !em && po == OP_READ;
      op <= sdram_op_e'($urandom_range(6));
      sdram_iface_disable <= ph && $urandom_range(7) == 0;
      {sdram_access, sdram_a10_val, ext_addr_bit10, clk_en_req} <= 4'($urandom);
      init_done <= ph;
      @(negedge ref_clk);
      chk({sdram_row_strobe_n, sdram_col_strobe_n, sdram_write_en_n}, pd ? 3'h7 : enc(po));
      chk({sdram_data_mask, sdram_clk_en, sdram_addr_bit10, sdram_clk_out}, {em, ek, ea, ec});
      chk({ctrl_oe, clk_oe, addr_bit10_oe, addr_bit10_out}, {2'h3, !(pa && !pd), pe});
    end
  endtask
  initial forever #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (++cyc == 2000) begin
    error_cnt++;
    final_report;
  end
  initial begin
    nrst <= 1'b0;
    void'($urandom(21663));
    repeat (16) @(posedge ref_clk);
    chk({ctrl_oe, clk_oe, addr_bit10_oe, sdram_row_strobe_n, sdram_col_strobe_n,
         sdram_write_en_n, sdram_data_mask, sdram_clk_out}, 8'h1e);
    chk({sdram_clk_en, sdram_addr_bit10}, 2'h3);
    nrst <= 1;
    run(300, 0);
    $display("masked phase done");
    run(600, 1);
    $display("running phase done");
    @(posedge ref_clk);
    @(negedge ref_clk);
    chk(wr_cnt, wr);
    chk(rd_cnt, rd);
    final_report;
  end
endmodule
`default_nettype wire
